/* fcc_pkg.sv */
// Shared constants, types and helpers of the flash command control block.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package fcc_pkg;

  // Register byte offsets (low address bits only)
  localparam int ADR_W = 8;
  localparam logic [7:0] OFF_ADDR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_INTR = 8'h24;
  localparam logic [7:0] OFF_DATA0 = 8'h30;
  localparam logic [7:0] OFF_DATA1 = 8'h34;
  localparam logic [7:0] OFF_DATA2 = 8'h38;
  localparam logic [7:0] OFF_DATA3 = 8'h3C;

  // Command and control register fields
  localparam int UNLOCK_LSB = 28;
  localparam int LVE_BIT = 25;
  localparam int BUSY_BIT = 24;
  localparam int ERASE_LSB = 8;
  localparam int PGE_BIT = 2;
  localparam int ME_BIT = 1;
  localparam int WR_BIT = 0;

  // Event flag register fields
  localparam int AF_BIT = 1;
  localparam int DONE_BIT = 0;

  // Key values
  localparam logic [3:0] UNLOCK_CODE = 4'h2;
  localparam logic [7:0] ERASE_NONE = 8'h00;
  localparam logic [7:0] ERASE_PAGE = 8'h55;
  localparam logic [7:0] ERASE_MASS = 8'hAA;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_UNLOCK = 4'h0;

  typedef enum logic [1:0] {OpProg, OpPage, OpMass} fcc_op_t;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] fccMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

/* fcc_ifs.sv */
// Internal carriers between the flash command control core and its helpers.
// Assumes all ends run on the same clock.
`timescale 1ns/1ps
interface fcc_bus_if;
  logic wrEn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] sel;
  logic [31:0] rdData;
  modport slave(output wrEn, addr, wdata, sel, input rdData);
  modport core(input wrEn, addr, wdata, sel, output rdData);
endinterface

interface fcc_op_if;
  import fcc_pkg::*;
  logic start;
  fcc_op_t kind;
  logic finish;
  logic flashReq;
  fcc_op_t flashKind;
  logic flashDone;
  modport engine(input start, kind, flashDone,
                 output finish, flashReq, flashKind);
  modport core(output start, kind, flashDone,
               input finish, flashReq, flashKind);
endinterface

/* fcc_wb_slave.sv */
// Classic Wishbone slave front end: one wait state, registered ack and data.
// Assumes the master holds its request until it samples ack.
`timescale 1ns/1ps
module fcc_wb_slave
  import fcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatIn,
  input wire logic [3:0] wbSel,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  fcc_bus_if.slave bus
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdData;
  } fcc_wb_state_t;

  fcc_wb_state_t q;
  fcc_wb_state_t d;

  always_comb begin
    d = q;
    // Ack drops the cycle after it was given, even if stb stays high
    d.ack = wbCyc && wbStb && !q.ack;
    if (wbCyc && wbStb && !q.ack) begin
      d.rdData = bus.rdData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Writes commit on the edge where the master samples ack
  assign bus.wrEn = wbCyc && wbStb && wbWe && q.ack;
  assign bus.addr = wbAdr;
  assign bus.wdata = wbDatIn;
  assign bus.sel = wbSel;
  assign wbAck = q.ack;
  assign wbDatOut = q.rdData;

endmodule

/* fcc_op_engine.sv */
// Sequencer for one program or erase operation against the flash array.
// Assumes the array answers each request with a one-cycle done pulse.
`timescale 1ns/1ps
module fcc_op_engine
  import fcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  fcc_op_if.engine op
);

  typedef enum logic {Idle, Run} fcc_eng_st_t;

  typedef struct packed {
    fcc_eng_st_t st;
    fcc_op_t kind;
  } fcc_eng_state_t;

  fcc_eng_state_t q;
  fcc_eng_state_t d;

  always_comb begin
    d = q;
    unique case (q.st)
      Idle: begin
        if (op.start) begin
          d.st = Run;
          d.kind = op.kind;
        end
      end
      Run: begin
        if (op.flashDone) begin
          d.st = Idle;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{st: Idle, kind: OpProg};
    end else begin
      q <= d;
    end
  end

  // Request held as a level so a slow array cannot miss it
  assign op.flashReq = (q.st == Run);
  assign op.flashKind = q.kind;
  assign op.finish = (q.st == Run) && op.flashDone;

endmodule

/* flash_command_control.sv */
// Command and control register core of an on-chip flash controller.
// Assumes a classic Wishbone master and a flash array on the same clock.
//
// What this block does
// - Any other key value keeps flash locked
// - Low-voltage enable bit, read-write, resets 0
// - Busy ignores writes except event flag register
// - Hardware clears busy when flash is free
// - Start write or array read while busy refused, sets access-fail
// - Erase key 0x55 page, 0xAA mass
// - Erase key cleared when erase completes
// - Page start erases page at target location
// - Page start reads 1 until erase done
// - Whole start erases the entire flash
// - Whole start reads 1 until erase done
// - Program start writes staged words at target
// - Program start reads 1 while programming
// - Completion flag set after every operation
// - Busy or locked attempt sets access-fail
// - Four data words form 128 bits, highest top
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module flash_command_control
  import fcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic flashReq,
  output fcc_op_t flashKind,
  output logic [31:0] flashAddr,
  output logic [127:0] flashData,
  output logic flashLowVolt,
  input wire logic flashDone,
  input wire logic readAttempt,
  output logic flashBusy
);

  typedef struct packed {
    logic [31:0] targetAddr;
    logic [3:0] unlockKey;
    logic lowVolt;
    logic busy;
    logic [7:0] eraseKey;
    logic pageStart;
    logic wholeStart;
    logic progStart;
    logic accessFail;
    logic opDone;
    logic [3:0][31:0] progWord;
  } fcc_core_state_t;

  fcc_core_state_t q;
  fcc_core_state_t d;

  fcc_bus_if bus();
  fcc_op_if op();

  logic [31:0] ctrlView;
  logic [31:0] intrView;

  fcc_wb_slave u_wb (
    .ref_clk(ref_clk),
    .srst(srst),
    .wbCyc(wb_cyc_i),
    .wbStb(wb_stb_i),
    .wbWe(wb_we_i),
    .wbAdr(wb_adr_i[7:0]),
    .wbDatIn(wb_dat_i),
    .wbSel(wb_sel_i),
    .wbAck(wb_ack_o),
    .wbDatOut(wb_dat_o),
    .bus(bus)
  );

  fcc_op_engine u_eng (
    .ref_clk(ref_clk),
    .srst(srst),
    .op(op)
  );

  // Readable images of the control and event registers
  always_comb begin
    ctrlView = RST_WORD;
    ctrlView[UNLOCK_LSB +: 4] = q.unlockKey;
    ctrlView[LVE_BIT] = q.lowVolt;
    ctrlView[BUSY_BIT] = q.busy;
    ctrlView[ERASE_LSB +: 8] = q.eraseKey;
    ctrlView[PGE_BIT] = q.pageStart;
    ctrlView[ME_BIT] = q.wholeStart;
    ctrlView[WR_BIT] = q.progStart;
    intrView = RST_WORD;
    intrView[AF_BIT] = q.accessFail;
    intrView[DONE_BIT] = q.opDone;
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    unique case (bus.addr)
      OFF_ADDR: bus.rdData = q.targetAddr;
      OFF_CTRL: bus.rdData = ctrlView;
      OFF_INTR: bus.rdData = intrView;
      OFF_DATA0: bus.rdData = q.progWord[0];
      OFF_DATA1: bus.rdData = q.progWord[1];
      OFF_DATA2: bus.rdData = q.progWord[2];
      OFF_DATA3: bus.rdData = q.progWord[3];
      default: bus.rdData = RST_WORD;
    endcase
  end

  logic [31:0] ctrlNew;
  logic [31:0] intrNew;
  logic ctrlWr;
  logic intrWr;
  logic wantAny;
  logic keyOk;
  logic failNow;
  logic startNow;
  fcc_op_t startKind;

  // Decode of a control write into a start request or a refusal
  always_comb begin
    ctrlNew = fccMerge(ctrlView, bus.wdata, bus.sel);
    intrNew = fccMerge(intrView, bus.wdata, bus.sel);
    ctrlWr = bus.wrEn && (bus.addr == OFF_CTRL);
    intrWr = bus.wrEn && (bus.addr == OFF_INTR);
    wantAny = ctrlNew[WR_BIT] || ctrlNew[PGE_BIT] || ctrlNew[ME_BIT];
    keyOk = (ctrlNew[UNLOCK_LSB +: 4] == UNLOCK_CODE);
    startNow = 1'b0;
    startKind = OpProg;
    failNow = 1'b0;
    if (ctrlWr && wantAny) begin
      if (q.busy || !keyOk) begin
        failNow = 1'b1;
      end else if (ctrlNew[WR_BIT]) begin
        startNow = 1'b1;
        startKind = OpProg;
      end else if (ctrlNew[PGE_BIT]) begin
        // Only the matching key starts an erase
        if (ctrlNew[ERASE_LSB +: 8] == ERASE_PAGE) begin
          startNow = 1'b1;
          startKind = OpPage;
        end else begin
          failNow = 1'b1;
        end
      end else begin
        if (ctrlNew[ERASE_LSB +: 8] == ERASE_MASS) begin
          startNow = 1'b1;
          startKind = OpMass;
        end else begin
          failNow = 1'b1;
        end
      end
    end
    // Reads of the array while busy count as failed accesses too
    if (readAttempt && q.busy) begin
      failNow = 1'b1;
    end
  end

  assign op.start = startNow;
  assign op.kind = startKind;
  assign op.flashDone = flashDone;

  always_comb begin
    d = q;
    // Everything except the event flag register is frozen while busy
    if (bus.wrEn && !q.busy) begin
      unique case (bus.addr)
        OFF_ADDR: d.targetAddr = fccMerge(q.targetAddr, bus.wdata, bus.sel);
        OFF_DATA0: d.progWord[0] = fccMerge(q.progWord[0], bus.wdata,
                                            bus.sel);
        OFF_DATA1: d.progWord[1] = fccMerge(q.progWord[1], bus.wdata,
                                            bus.sel);
        OFF_DATA2: d.progWord[2] = fccMerge(q.progWord[2], bus.wdata,
                                            bus.sel);
        OFF_DATA3: d.progWord[3] = fccMerge(q.progWord[3], bus.wdata,
                                            bus.sel);
        OFF_CTRL: begin
          d.unlockKey = ctrlNew[UNLOCK_LSB +: 4];
          d.lowVolt = ctrlNew[LVE_BIT];
          d.eraseKey = ctrlNew[ERASE_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
    // Start bits are set only by an accepted start, never cleared by software
    if (startNow) begin
      d.busy = 1'b1;
      d.progStart = (startKind == OpProg);
      d.pageStart = (startKind == OpPage);
      d.wholeStart = (startKind == OpMass);
    end
    // Software clears event flags by writing zero; writing one does nothing
    if (intrWr) begin
      if (!intrNew[AF_BIT]) begin
        d.accessFail = 1'b0;
      end
      if (!intrNew[DONE_BIT]) begin
        d.opDone = 1'b0;
      end
    end
    // Completion ends the operation; placed after writes so it wins
    if (op.finish) begin
      d.busy = 1'b0;
      d.progStart = 1'b0;
      d.pageStart = 1'b0;
      d.wholeStart = 1'b0;
      if (q.pageStart || q.wholeStart) begin
        d.eraseKey = ERASE_NONE;
      end
      d.opDone = 1'b1;
    end
    // Hardware set beats a software clear in the same cycle
    if (failNow) begin
      d.accessFail = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.unlockKey <= RST_UNLOCK;
      q.eraseKey <= ERASE_NONE;
    end else begin
      q <= d;
    end
  end

  // Array outputs; data and address are frozen by the busy write lock
  assign flashReq = op.flashReq;
  assign flashKind = op.flashKind;
  assign flashAddr = q.targetAddr;
  assign flashData = {q.progWord[3], q.progWord[2],
                      q.progWord[1], q.progWord[0]};
  assign flashLowVolt = q.lowVolt;
  assign flashBusy = q.busy;

endmodule

/* fcc_checker_sva.sv */
// Port-level checks of the flash command control block.
// Assumes control writes use all four byte lanes.
`timescale 1ns/1ps
module fcc_checker_sva
  import fcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic flashReq,
  input fcc_op_t flashKind,
  input wire logic flashLowVolt,
  input wire logic flashDone,
  input wire logic flashBusy
);
  logic ctrlWr;
  assign ctrlWr = wb_ack_o && wb_we_i && wb_adr_i[7:0] == OFF_CTRL
    && wb_sel_i == 4'hF;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence sOpen;
    ctrlWr && !flashBusy && wb_dat_i[31:28] == UNLOCK_CODE;
  endsequence
  sequence sBusyWr;
    ctrlWr && flashBusy && !flashDone;
  endsequence
  chk_prog_start: assert property (sOpen ##0 wb_dat_i[0]
    |=> flashReq && flashKind == OpProg) else $error("program not started");
  chk_page_start: assert property (sOpen ##0 (!wb_dat_i[0]
    && wb_dat_i[2] && wb_dat_i[15:8] == ERASE_PAGE)
    |=> flashReq && flashKind == OpPage) else $error("page not started");
  chk_mass_start: assert property (sOpen ##0 (wb_dat_i[2:0] == 3'h2
    && wb_dat_i[15:8] == ERASE_MASS)
    |=> flashReq && flashKind == OpMass) else $error("mass not started");
  chk_locked_idle: assert property (ctrlWr && !flashBusy
    && wb_dat_i[31:28] != UNLOCK_CODE |=> !flashReq)
    else $error("locked flash started");
  chk_no_key: assert property (sOpen ##0 (!wb_dat_i[0]
    && wb_dat_i[15:8] == ERASE_NONE) |=> !flashReq)
    else $error("erase without key");
  chk_lowvolt_wr: assert property (ctrlWr && !flashBusy
    |=> flashLowVolt == $past(wb_dat_i[25])) else $error("lve not written");
  chk_busy_ignore: assert property (sBusyWr |=> $stable(flashLowVolt))
    else $error("write taken while busy");
  chk_req_busy: assert property (flashReq |-> flashBusy)
    else $error("busy low during op");
  chk_done_clear: assert property (flashReq && flashDone
    |=> !flashBusy && !flashReq) else $error("busy not cleared");
  chk_req_hold: assert property (flashReq && !flashDone
    |=> flashReq && $stable(flashKind)) else $error("op dropped");
  chk_busy_cause: assert property ($rose(flashBusy) |-> $past(ctrlWr))
    else $error("busy without start");
endmodule
bind flash_command_control fcc_checker_sva u_chk (.ref_clk(ref_clk),
  .srst(srst), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .flashReq(flashReq),
  .flashKind(flashKind), .flashLowVolt(flashLowVolt),
  .flashDone(flashDone), .flashBusy(flashBusy));

/* fcc_flash_model.sv */
// Behavioural flash array: one done pulse per request.
// Assumes the request stays up until done is seen.
`timescale 1ns/1ps
module fcc_flash_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic flashReq,
  input wire logic [3:0] waitCycles,
  output logic flashDone
);
  logic [3:0] cnt_q;
  // Restart on every pulse so a held request cannot double-finish
  always_ff @(posedge ref_clk) begin
    if (srst || !flashReq || flashDone) begin
      cnt_q <= 4'h0;
      flashDone <= 1'b0;
    end else if (cnt_q == waitCycles) begin
      flashDone <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

/* flash_command_control_tb_top.sv */
// Self-checking bench for the flash command control block.
// Assumes the array model answers after waitCyc cycles.
`timescale 1ns/1ps
module flash_command_control_tb_top
  import fcc_pkg::*;
;
  logic ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, prevReq;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, flashAddr, addrV, cmd;
  logic [31:0] w[4];
  logic [3:0] wb_sel_i, waitCyc;
  logic flashReq, flashLowVolt, flashDone, readAttempt, flashBusy;
  logic [127:0] flashData;
  logic [31:0] expRd[$];
  logic [162:0] expOp[$];
  fcc_op_t flashKind;
  int badCount = 0;
  int nCompared = 0;
  flash_command_control u_dut (.ref_clk(ref_clk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .flashReq(flashReq),
    .flashKind(flashKind), .flashAddr(flashAddr), .flashData(flashData),
    .flashLowVolt(flashLowVolt), .flashDone(flashDone),
    .readAttempt(readAttempt), .flashBusy(flashBusy));
  fcc_flash_model u_flash (.ref_clk(ref_clk), .srst(srst),
    .flashReq(flashReq), .waitCycles(waitCyc), .flashDone(flashDone));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [162:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finishTest();
    if (badCount == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h00_0000, a};
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      badCount++;
      finishTest();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expRd.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic waitIdle();
    int k;
    k = 0;
    while (flashBusy !== 1'b0 && k < 50) begin
      @(posedge ref_clk);
      k++;
    end
    if (flashBusy !== 1'b0) begin
      badCount++;
      finishTest();
    end
  endtask
  // Read data and each new array request are matched against the notes
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check("read", wb_dat_o, expRd.size() ? expRd.pop_front() : '1);
    end
    if (flashReq === 1'b1 && prevReq !== 1'b1) begin
      check("op", {flashKind, flashLowVolt, flashAddr, flashData},
        expOp.size() ? expOp.pop_front() : '1);
      check("busy", 163'(flashBusy), 163'd1);
    end
    prevReq <= flashReq;
  end
  initial begin
    srst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, readAttempt} = 4'h0;
    wb_adr_i = 32'h0000_0000;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    waitCyc = 4'hF;
    void'($urandom(32'hbd9e));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(OFF_CTRL, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    bus(1'b1, OFF_CTRL, 32'h3000_0001);
    rd(OFF_CTRL, 32'h3000_0000);
    rd(OFF_INTR, 32'h0000_0002);
    bus(1'b1, OFF_INTR, 32'h0000_0000);
    bus(1'b1, OFF_INTR, 32'h0000_0003);
    rd(OFF_INTR, 32'h0000_0000);
    addrV = $urandom();
    bus(1'b1, OFF_ADDR, addrV);
    for (int i = 0; i < 4; i++) begin
      w[i] = $urandom();
      bus(1'b1, OFF_DATA0 + 8'(4 * i), w[i]);
    end
    expOp.push_back({OpProg, 1'b1, addrV,
      w[3], w[2], w[1], w[0]});
    bus(1'b1, OFF_CTRL, 32'h2200_0001);
    rd(OFF_CTRL, 32'h2300_0001);
    bus(1'b1, OFF_CTRL, 32'h0000_0000);
    rd(OFF_CTRL, 32'h2300_0001);
    readAttempt <= 1'b1;
    @(posedge ref_clk);
    readAttempt <= 1'b0;
    waitIdle();
    rd(OFF_CTRL, 32'h2200_0000);
    rd(OFF_INTR, 32'h0000_0003);
    bus(1'b1, OFF_INTR, 32'h0000_0000);
    waitCyc <= 4'hC;
    for (int i = 0; i < 2; i++) begin
      cmd = i ? 32'h2000_AA02 : 32'h2000_5504;
      expOp.push_back({i ? OpMass : OpPage, 1'b0, addrV,
        w[3], w[2], w[1], w[0]});
      bus(1'b1, OFF_CTRL, cmd);
      rd(OFF_CTRL, cmd | 32'h0100_0000);
      waitIdle();
      rd(OFF_CTRL, 32'h2000_0000);
      rd(OFF_INTR, 32'h0000_0001);
      bus(1'b1, OFF_INTR, 32'h0000_0000);
    end
    bus(1'b1, OFF_CTRL, 32'h2000_5502);
    rd(OFF_CTRL, 32'h2000_5500);
    bus(1'b1, OFF_CTRL, 32'h2000_0004);
    rd(OFF_INTR, 32'h0000_0002);
    // Prompt array answer: done arrives right after the request
    waitCyc <= 4'h0;
    expOp.push_back({OpProg, 1'b0, addrV,
      w[3], w[2], w[1], w[0]});
    bus(1'b1, OFF_CTRL, 32'h2000_0001);
    waitIdle();
    rd(OFF_INTR, 32'h0000_0003);
    check("ops left", 163'(expOp.size()), 163'd0);
    check("reads left", 163'(expRd.size()), 163'd0);
    finishTest();
  end
endmodule
